// ### verilog/awsc_regs.sv
/*
 * Area bus width and access-state configuration bank with a classic Wishbone slave.
 * Assumes synchronous inputs, a boot width strap stable around reset, and a
 * master that holds each request until it samples ack.
 */
`timescale 1ns/100ps
module awsc_regs
    import awsc_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Boot strap
    input  wire logic                       boot_16bit_i,
    // Wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [awsc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    // Area settings
    output logic [awsc_pkg::AREA_N-1:0]     area_16bit_o,
    output logic [awsc_pkg::AREA_N-1:0]     area_width_bad_o,
    output logic [awsc_pkg::AREA_N-1:0]     area_three_state_o,
    output logic [awsc_pkg::AREA_N*awsc_pkg::WAIT_W-1:0] area_wait_o
);
    import awsc_pkg::*;

    logic [15:0] width_r;
    logic [7:0]  astate_r;
    logic [23:0] wait_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_nxt;
    logic        req;
    logic        wr_go;
    logic [15:0] wdat;
    logic [15:0] bmask;

    awsc_cfg_if cfg_if ();

    // Pack four 3-bit wait fields into nibbles, bit 3 of each reading zero
    function automatic logic [15:0] awsc_pack(input logic [11:0] w);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            v[i*4 +: 3] = w[i*3 +: 3];
        end
        return v;
    endfunction : awsc_pack

    function automatic logic [11:0] awsc_unpack(input logic [15:0] v);
        logic [11:0] w;
        w = 12'h000;
        for (int i = 0; i < 4; i++) begin
            w[i*3 +: 3] = v[i*4 +: 3];
        end
        return w;
    endfunction : awsc_unpack

    assign req   = wb_cyc_i & wb_stb_i;
    assign wr_go = req & wb_we_i & ack_r;
    assign bmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat  = wb_dat_i[15:0];

    // Bus answer: one ack per request, released the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (wb_adr_i)
            OFF_WIDTH:   rd_nxt[15:0] = width_r;
            OFF_ASTATE:  rd_nxt[15:0] = {astate_r, 8'h00};
            OFF_WAIT_UP: rd_nxt[15:0] = awsc_pack(wait_r[23:12]);
            OFF_WAIT_LO: rd_nxt[15:0] = awsc_pack(wait_r[11:0]);
            default:     rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req & ~ack_r) begin
            dat_r <= rd_nxt;
        end
    end

    // Bus width register, reset value follows the boot width strap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            width_r <= boot_16bit_i ? WIDTH_RST_16 : WIDTH_RST_8;
        end else if (wr_go && wb_adr_i == OFF_WIDTH) begin
            width_r <= (width_r & ~bmask) | (wdat & bmask);
        end
    end

    // Access-state register, only the upper byte is stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            astate_r <= ASTATE_RST;
        end else if (wr_go && wb_adr_i == OFF_ASTATE && wb_sel_i[1]) begin
            astate_r <= wdat[15:8];
        end
    end

    // Wait count registers, areas 7..4 upper and 3..0 lower
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_r <= {AREA_N{WAIT_RST}};
        end else if (wr_go && wb_adr_i == OFF_WAIT_UP) begin
            wait_r[23:12] <= awsc_unpack((awsc_pack(wait_r[23:12]) & ~bmask) | (wdat & bmask));
        end else if (wr_go && wb_adr_i == OFF_WAIT_LO) begin
            wait_r[11:0] <= awsc_unpack((awsc_pack(wait_r[11:0]) & ~bmask) | (wdat & bmask));
        end
    end

    assign cfg_if.width_high  = width_r[WIDTH_HI_LSB +: AREA_N];
    assign cfg_if.width_low   = width_r[WIDTH_LO_LSB +: AREA_N];
    assign cfg_if.three_state = astate_r;
    assign cfg_if.wait_cnt    = wait_r;

    awsc_area_decode #(
        .N (AREA_N)
    ) u_decode (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .cfg                (cfg_if.dec),
        .area_16bit_o       (area_16bit_o),
        .area_width_bad_o   (area_width_bad_o),
        .area_three_state_o (area_three_state_o),
        .area_wait_o        (area_wait_o)
    );

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
endmodule : awsc_regs

// ### verilog/awsc_pkg.sv
/*
 * Constants for the area width and access-state configuration bank.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
package awsc_pkg;
    localparam int          AREA_N        = 8;
    localparam int          WAIT_W        = 3;
    localparam int          ADR_W         = 8;
    // Byte offsets of the registers
    localparam logic [7:0]  OFF_WIDTH     = 8'h00;
    localparam logic [7:0]  OFF_ASTATE    = 8'h04;
    localparam logic [7:0]  OFF_WAIT_UP   = 8'h08;
    localparam logic [7:0]  OFF_WAIT_LO   = 8'h0C;
    // Field positions
    localparam int          WIDTH_HI_LSB  = 8;
    localparam int          WIDTH_LO_LSB  = 0;
    localparam int          ASTATE_LSB    = 8;
    // Values after reset
    localparam logic [15:0] WIDTH_RST_16  = 16'hFEFF;
    localparam logic [15:0] WIDTH_RST_8   = 16'hFFFF;
    localparam logic [7:0]  ASTATE_RST    = 8'hFF;
    localparam logic [2:0]  WAIT_RST      = 3'h7;
endpackage : awsc_pkg

// ### verilog/awsc_cfg_if.sv
/*
 * Raw per-area configuration fields passed from the register bank to the decoder.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
interface awsc_cfg_if;
    logic [7:0]  width_high;
    logic [7:0]  width_low;
    logic [7:0]  three_state;
    logic [23:0] wait_cnt;

    modport src (output width_high, output width_low, output three_state, output wait_cnt);
    modport dec (input width_high, input width_low, input three_state, input wait_cnt);
endinterface : awsc_cfg_if

// ### verilog/awsc_area_decode.sv
/*
 * Per-area decode of width, access states and effective wait count, registered.
 * Assumes raw fields from the register bank on the same clock.
 */
`timescale 1ns/100ps
module awsc_area_decode
    import awsc_pkg::*;
#(
    parameter int N = awsc_pkg::AREA_N
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Raw fields
    awsc_cfg_if.dec                cfg,
    // Decoded settings
    output logic [N-1:0]           area_16bit_o,
    output logic [N-1:0]           area_width_bad_o,
    output logic [N-1:0]           area_three_state_o,
    output logic [N*WAIT_W-1:0]    area_wait_o
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_area
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    area_16bit_o[g]       <= 1'b0;
                    area_width_bad_o[g]   <= 1'b0;
                    area_three_state_o[g] <= 1'b1;
                    area_wait_o[g*WAIT_W +: WAIT_W] <= WAIT_RST;
                end else begin
                    area_16bit_o[g]       <= ~cfg.width_high[g] & cfg.width_low[g];
                    area_width_bad_o[g]   <= ~cfg.width_low[g];
                    area_three_state_o[g] <= cfg.three_state[g];
                    area_wait_o[g*WAIT_W +: WAIT_W] <= cfg.three_state[g] ?
                        cfg.wait_cnt[g*WAIT_W +: WAIT_W] : 3'h0;
                end
            end
        end
    endgenerate
endmodule : awsc_area_decode

// ### test/awsc_regs_properties.sv
/* Port assertions for the area width and access-state bank.
   Assumes it is bound to awsc_regs, one clock, synchronous reset. */
`timescale 1ns/100ps
module awsc_regs_properties
    import awsc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        boot_16bit_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  area_16bit_o,
    input wire logic [7:0]  area_width_bad_o,
    input wire logic [7:0]  area_three_state_o,
    input wire logic [23:0] area_wait_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire wr_w = req & wb_we_i & (wb_adr_i == OFF_WIDTH) & (&wb_sel_i[1:0]);
    AST_ACK_PULSE: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one pulse after a request");
    AST_WIDTH_LOW: assert property (wr_w |=> ##2
        area_width_bad_o == ~$past(wb_dat_i[7:0], 3)) else $error("low bits not decoded");
    AST_WIDTH_16: assert property (wr_w |=> ##2 area_16bit_o ==
        (~$past(wb_dat_i[15:8], 3) & $past(wb_dat_i[7:0], 3))) else $error("16-bit decode");
    AST_RST_WIDTH: assert property ($fell(rst_i) |=>
        area_16bit_o == {7'h00, $past(boot_16bit_i, 2)}) else $error("width after reset");
    AST_RST_ASTATE: assert property ($fell(rst_i) |-> area_three_state_o == 8'hFF ##1
        area_three_state_o == 8'hFF) else $error("access state after reset");
    AST_ASTATE_WR: assert property (req & wb_we_i & (wb_adr_i == OFF_ASTATE) & wb_sel_i[1]
        |=> ##2 area_three_state_o == $past(wb_dat_i[15:8], 3)) else $error("state write");
    AST_RD_LOW_ZERO: assert property (req & !wb_we_i & (wb_adr_i == OFF_ASTATE)
        |=> wb_dat_o[7:0] == 8'h00) else $error("state low byte not zero");
    for (genvar k = 0; k < AREA_N; k++) begin : g_wait
        AST_WAIT_GATE: assert property (!area_three_state_o[k] |->
            area_wait_o[3*k+:3] == 3'h0) else $error("wait in two-state area");
    end
endmodule : awsc_regs_properties
bind awsc_regs awsc_regs_properties awsc_regs_properties_i (.*);

// ### test/awsc_ext_mem_model.sv
/* External memory that reports how many states an access to one area takes.
   Assumes settings straight from awsc_regs. */
`timescale 1ns/100ps
module awsc_ext_mem_model
    import awsc_pkg::*;
(
    // Area settings and selected area
    input  wire logic [awsc_pkg::AREA_N-1:0]        three_state_i,
    input  wire logic [awsc_pkg::AREA_N*WAIT_W-1:0] wait_i,
    input  wire logic [2:0]                         area_i,
    // Access length in states
    output logic [3:0]                              states_o
);
    // Byte-control SRAM sits on area 0, which software keeps 16-bit
    assign states_o = three_state_i[area_i] ? 4'h3 + 4'(wait_i[area_i*3+:3]) : 4'h2;
endmodule : awsc_ext_mem_model

// ### test/awsc_regs_tb_top.sv
/* Self-checking bench for the area width and access-state bank.
   Assumes the bound checker and a 20 MHz clock. */
`timescale 1ns/100ps
module awsc_regs_tb_top;
    import awsc_pkg::*;
    typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] r;} awsc_row_t;
    logic        clk_i = 1'b0, rst_i = 1'b1, boot_16bit_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]  wb_adr_i = 8'h00, area_16bit_o, area_width_bad_o, area_three_state_o;
    logic [3:0]  wb_sel_i = 4'hF, states;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic [23:0] area_wait_o;
    logic [15:0] q;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    awsc_row_t   rows [6] = '{'{8'h00, 16'h00FF, 16'h00FF}, '{8'h00, 16'hF00F, 16'hF00F},
        '{8'h04, 16'hA5FF, 16'hA500}, '{8'h08, 16'hFFFF, 16'h7777},
        '{8'h0C, 16'h0123, 16'h0123}, '{8'h01, 16'hFFFF, 16'h0000}};
    awsc_regs awsc_regs_i (.*);
    awsc_ext_mem_model awsc_ext_mem_model_i (.three_state_i(area_three_state_o),
        .wait_i(area_wait_o), .area_i(3'h0), .states_o(states));
    always #25 clk_i = ~clk_i;
    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset(input logic b);
        boot_16bit_i <= b;
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : do_reset
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        do_reset(1'b1);
        chk(area_16bit_o, 8'h01);
        chk(states, 4'hA);
        xfer(8'h00, 1'b0, 16'h0000); chk(q, 16'hFEFF);
        xfer(8'h04, 1'b0, 16'h0000); chk(q, 16'hFF00);
        $display("reset test done");
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b1, rows[i].w);
            xfer(rows[i].a, 1'b0, 16'h0000);
            chk(q, rows[i].r);
        end
        $display("row test done");
        xfer(8'h04, 1'b1, 16'h0F00);
        xfer(8'h0C, 1'b1, 16'h1234);
        @(posedge clk_i);
        chk(area_wait_o, {12'h000, 3'h1, 3'h2, 3'h3, 3'h4});
        chk(states, 4'h7);
        chk(area_width_bad_o, 8'hF0);
        $display("wait test done");
        do_reset(1'b0);
        chk(area_16bit_o, 8'h00);
        xfer(8'h00, 1'b0, 16'h0000); chk(q, 16'hFFFF);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule : awsc_regs_tb_top
